/* File: shared/hs_counter_pkg.sv */
// constants and types shared by the high-speed counter groups
package hs_counter_pkg;

  localparam int GROUPS = 4;
  localparam int COUNT_W = 16;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  localparam int GROUP_STRIDE = 4;

  // register indexes on the plain register port
  localparam logic [3:0] OFF_METHOD = 4'h0;
  localparam logic [3:0] OFF_REQ = 4'h1;
  localparam logic [3:0] OFF_DONE = 4'h2;
  localparam logic [3:0] OFF_RUN_CTRL = 4'h3;
  localparam logic [3:0] OFF_RUN_STAT = 4'h4;
  localparam logic [3:0] OFF_READBACK = 4'h5;
  localparam logic [3:0] OFF_COUNT0 = 4'h8;

  // field positions inside a group nibble
  localparam int BIT_DIR = 0;
  localparam int BIT_EDGE = 1;
  localparam int BIT_CHG = 0;
  localparam int BIT_RD = 1;
  localparam int BIT_RUN = 0;
  localparam int METHOD_W = 2;

  // writable bits
  localparam logic [15:0] MASK_METHOD = 16'h3333;
  localparam logic [15:0] MASK_REQ = 16'h3333;
  localparam logic [15:0] MASK_RUN = 16'h1111;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_COUNT = 16'h0000;
  localparam logic [1:0] RST_METHOD = 2'h0;

  // pulse rate ceiling and the resulting cycles per input period
  localparam int MAX_RATE_HZ = 10000;
  localparam int CLK_HZ = 40000000;
  localparam int MIN_PERIOD_CYC = CLK_HZ / MAX_RATE_HZ;

  typedef enum logic [0:0] {
    HS_IDLE = 1'b0,
    HS_DONE = 1'b1
  } hs_state_t;

endpackage : hs_counter_pkg

/* File: design/pin_edge_sync.sv */
// three-stage pin synchroniser with qualified rise and fall pulses
`timescale 1ns/100ps
`default_nettype none
module pin_edge_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  typedef struct packed {
    logic [2:0] sh;
    logic stable;
    logic rise;
    logic fall;
  } sync_state_t;

  sync_state_t q;
  sync_state_t d;

  always_comb begin
    d = q;
    d.sh = {q.sh[1:0], pin};
    d.rise = 1'b0;
    d.fall = 1'b0;
    // second and third stage must agree before a change counts
    if (q.sh[2] == q.sh[1] && q.sh[2] != q.stable) begin
      d.stable = q.sh[2];
      d.rise = q.sh[2];
      d.fall = ~q.sh[2];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rise = q.rise;
  assign fall = q.fall;

endmodule : pin_edge_sync
`default_nettype wire

/* File: design/updown_count_group.sv */
// one group's up/down pulse counter
`timescale 1ns/100ps
`default_nettype none
module updown_count_group #(
  parameter int COUNT_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic rise,
  input wire logic fall,
  input wire logic enable,
  input wire logic clear,
  input wire logic dir_down,
  input wire logic edge_fall,
  output logic [COUNT_W-1:0] count
);

  generate
    if (COUNT_W < 1 || COUNT_W > 16) begin : g_bad_width
      $error("count width must be 1 to 16");
    end
  endgenerate

  typedef struct packed {
    logic [COUNT_W-1:0] count;
  } grp_state_t;

  grp_state_t q;
  grp_state_t d;
  logic tick;

  assign tick = edge_fall ? fall : rise;

  always_comb begin
    d = q;
    if (clear) begin
      d.count = '0;
    end else if (enable && tick) begin
      // natural wrap at both ends
      if (dir_down) begin
        d.count = COUNT_W'(q.count - 1'b1);
      end else begin
        d.count = COUNT_W'(q.count + 1'b1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign count = q.count;

endmodule : updown_count_group
`default_nettype wire

/* File: design/hs_updown_counter_groups.sv */
// four-group high-speed up/down pulse counter with register port
`timescale 1ns/100ps
`default_nettype none
module hs_updown_counter_groups #(
  parameter int GROUPS = hs_counter_pkg::GROUPS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [hs_counter_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [hs_counter_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [hs_counter_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [GROUPS-1:0] count_pin,
  input wire logic prog_halt,
  input wire logic unit_offline
);

  localparam int CW = hs_counter_pkg::COUNT_W;
  localparam int MW = hs_counter_pkg::METHOD_W;
  localparam int ST = hs_counter_pkg::GROUP_STRIDE;

  generate
    if (GROUPS < 1 || GROUPS > 4) begin : g_bad_groups
      $error("group count must be 1 to 4");
    end
  endgenerate

  typedef struct packed {
    logic [15:0] method;
    logic [15:0] req;
    logic [15:0] run;
    logic [15:0] readback;
    logic [GROUPS-1:0][MW-1:0] applied;
    hs_counter_pkg::hs_state_t [GROUPS-1:0] chg;
    hs_counter_pkg::hs_state_t [GROUPS-1:0] rd;
    logic [15:0] rdata;
  } top_state_t;

  top_state_t q;
  top_state_t d;

  logic [GROUPS-1:0] rise;
  logic [GROUPS-1:0] fall;
  logic [GROUPS-1:0][CW-1:0] count;
  logic [GROUPS-1:0] active;
  logic [15:0] done_word;
  logic [15:0] stat_word;

  // one terminal per group: single-phase variant only
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    pin_edge_sync u_sync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .pin(count_pin[g]),
      .rise(rise[g]),
      .fall(fall[g])
    );

    // running and not offline; halt only pauses, status stays up
    assign active[g] = q.run[g*ST + hs_counter_pkg::BIT_RUN]
      && !unit_offline;

    // applied method drives the counter live, so a switch mid-count
    // may drop the pulse arriving in the same cycle
    updown_count_group #(
      .COUNT_W(CW)
    ) u_cnt (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .rise(rise[g]),
      .fall(fall[g]),
      .enable(active[g] && !prog_halt),
      .clear(unit_offline),
      .dir_down(q.applied[g][hs_counter_pkg::BIT_DIR]),
      .edge_fall(q.applied[g][hs_counter_pkg::BIT_EDGE]),
      .count(count[g])
    );
  end

  always_comb begin
    done_word = '0;
    stat_word = '0;
    for (int g = 0; g < GROUPS; g++) begin
      done_word[g*ST + hs_counter_pkg::BIT_CHG] =
        (q.chg[g] == hs_counter_pkg::HS_DONE);
      done_word[g*ST + hs_counter_pkg::BIT_RD] =
        (q.rd[g] == hs_counter_pkg::HS_DONE);
      stat_word[g*ST + hs_counter_pkg::BIT_RUN] = active[g];
    end
  end

  always_comb begin
    d = q;
    d.rdata = '0;

    if (reg_wr) begin
      case (reg_addr)
        hs_counter_pkg::OFF_METHOD: begin
          d.method = reg_wdata & hs_counter_pkg::MASK_METHOD;
        end
        hs_counter_pkg::OFF_REQ: begin
          d.req = reg_wdata & hs_counter_pkg::MASK_REQ;
        end
        hs_counter_pkg::OFF_RUN_CTRL: begin
          d.run = reg_wdata & hs_counter_pkg::MASK_RUN;
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        hs_counter_pkg::OFF_METHOD: d.rdata = q.method;
        hs_counter_pkg::OFF_REQ: d.rdata = q.req;
        hs_counter_pkg::OFF_DONE: d.rdata = done_word;
        hs_counter_pkg::OFF_RUN_CTRL: d.rdata = q.run;
        hs_counter_pkg::OFF_RUN_STAT: d.rdata = stat_word;
        hs_counter_pkg::OFF_READBACK: d.rdata = q.readback;
        default: begin
          // counts sit at consecutive indexes from the first
          for (int g = 0; g < GROUPS; g++) begin
            if (reg_addr == 4'(hs_counter_pkg::OFF_COUNT0 + g)) begin
              d.rdata = 16'(count[g]);
            end
          end
        end
      endcase
    end

    // each group touches only its own slice
    for (int g = 0; g < GROUPS; g++) begin
      case (q.chg[g])
        hs_counter_pkg::HS_IDLE: begin
          if (q.req[g*ST + hs_counter_pkg::BIT_CHG]) begin
            // whole method field taken at once
            d.applied[g] = q.method[g*ST +: MW];
            d.chg[g] = hs_counter_pkg::HS_DONE;
          end
        end
        hs_counter_pkg::HS_DONE: begin
          // relies on software waiting for done before dropping
          if (!q.req[g*ST + hs_counter_pkg::BIT_CHG]) begin
            d.chg[g] = hs_counter_pkg::HS_IDLE;
          end
        end
        default: d.chg[g] = hs_counter_pkg::HS_IDLE;
      endcase

      case (q.rd[g])
        hs_counter_pkg::HS_IDLE: begin
          if (q.req[g*ST + hs_counter_pkg::BIT_RD]) begin
            d.readback[g*ST +: MW] = q.applied[g];
            d.rd[g] = hs_counter_pkg::HS_DONE;
          end
        end
        hs_counter_pkg::HS_DONE: begin
          if (!q.req[g*ST + hs_counter_pkg::BIT_RD]) begin
            d.rd[g] = hs_counter_pkg::HS_IDLE;
          end
        end
        default: d.rd[g] = hs_counter_pkg::HS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q.method <= hs_counter_pkg::RST_WORD;
      q.req <= hs_counter_pkg::RST_WORD;
      q.run <= hs_counter_pkg::RST_WORD;
      q.readback <= hs_counter_pkg::RST_WORD;
      q.applied <= '0;
      q.chg <= '{default: hs_counter_pkg::HS_IDLE};
      q.rd <= '{default: hs_counter_pkg::HS_IDLE};
      q.rdata <= hs_counter_pkg::RST_WORD;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;

endmodule : hs_updown_counter_groups
`default_nettype wire

/* File: tb/hs_counter_monitor.sv */
// concurrent checks on the counter register port
`timescale 1ns/100ps
`default_nettype none
module hs_counter_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [hs_counter_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [hs_counter_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [hs_counter_pkg::DATA_W-1:0] reg_rdata,
  input wire logic prog_halt,
  input wire logic unit_offline
);
  logic [15:0] meth_q, req_q, run_q, c0_q;
  logic [3:0] hage_q;
  logic c0v_q;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meth_q <= 16'h0000;
      req_q <= 16'h0000;
      run_q <= 16'h0000;
      c0_q <= 16'h0000;
      hage_q <= 4'h0;
      c0v_q <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == 4'h0) meth_q <= reg_wdata & 16'h3333;
      if (reg_wr && reg_addr == 4'h1) req_q <= reg_wdata & 16'h3333;
      if (reg_wr && reg_addr == 4'h3) run_q <= reg_wdata & 16'h1111;
      // saturate at 8 so edges already in the synchroniser have landed
      hage_q <= (!prog_halt || unit_offline) ? 4'h0 :
        hage_q + {3'h0, hage_q != 4'h8};
      if ($past(reg_rd) && $past(reg_addr) == 4'h8) begin
        c0_q <= reg_rdata;
        c0v_q <= hage_q == 4'h8;
      end else if (hage_q != 4'h8) begin
        c0v_q <= 1'b0;
      end
    end
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read slot");
  a_unmapped_zero: assert property (reg_rd && reg_addr inside
    {4'h6, 4'h7, [4'hC:4'hF]} |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_method_rw: assert property (
    reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(meth_q))
    else $error("method word readback wrong");
  a_run_ctrl_rw: assert property (
    reg_rd && reg_addr == 4'h3 |=> reg_rdata == $past(run_q))
    else $error("run control readback wrong");
  a_done_follows_req: assert property (
    reg_rd && reg_addr == 4'h2 && $stable(req_q) |=>
    reg_rdata == $past(req_q))
    else $error("done word does not follow request");
  a_status_run: assert property (
    reg_rd && reg_addr == 4'h4 && $stable(run_q) && !unit_offline &&
    !$past(unit_offline) |=> reg_rdata == $past(run_q))
    else $error("run status wrong");
  a_offline_zero: assert property (
    reg_rd && (reg_addr[3] || reg_addr == 4'h4) && unit_offline &&
    $past(unit_offline) |=> reg_rdata == 16'h0000)
    else $error("offline count or status not zero");
  a_halt_hold: assert property (
    $past(reg_rd) && $past(reg_addr) == 4'h8 && c0v_q &&
    hage_q == 4'h8 |-> reg_rdata == c0_q)
    else $error("count moved while halted");
endmodule : hs_counter_monitor
bind hs_updown_counter_groups hs_counter_monitor i_mon (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .prog_halt(prog_halt),
  .unit_offline(unit_offline)
);
`default_nettype wire

/* File: tb/pulse_src.sv */
// pulse source model on the counter input pins
`timescale 1ns/100ps
`default_nettype none
module pulse_src (
  input wire logic core_clk,
  output logic [3:0] pins
);
  // pins idle low so no false edge follows reset
  logic [3:0] pin_q = 4'h0;
  assign pins = pin_q;
  // one edge per call, then half the shortest legal period
  task automatic step(input logic [3:0] m);
    @(posedge core_clk);
    pin_q <= pin_q ^ m;
    repeat (hs_counter_pkg::MIN_PERIOD_CYC / 2) @(posedge core_clk);
  endtask : step
endmodule : pulse_src
`default_nettype wire

/* File: tb/hs_updown_counter_groups_tb.sv */
// self-checking bench for the four-group counter
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %0t: got %h want %h", $time, g, e); end end
module hs_updown_counter_groups_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [3:0] count_pin;
  logic prog_halt = 1'b0;
  logic unit_offline = 1'b0;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #12.5 core_clk = ~core_clk;
  hs_updown_counter_groups i_dut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .count_pin(count_pin),
    .prog_halt(prog_halt),
    .unit_offline(unit_offline)
  );
  pulse_src i_src (
    .core_clk(core_clk),
    .pins(count_pin)
  );
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd
  task automatic hs(input logic [15:0] r);
    wr(4'h1, r);
    rd(4'h2, r);
    wr(4'h1, 16'h0000);
    rd(4'h2, 16'h0000);
  endtask : hs
  task automatic cnts(input logic [63:0] e);
    for (int g = 0; g < 4; g++) rd(4'h8 + 4'(g), e[16*g +: 16]);
  endtask : cnts
  task automatic tend(input string s);
    $display("test %s ends, mismatches %0d", s, n_mismatch);
  endtask : tend
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++) rd(4'(a), 16'h0000);
    tend("reset");
    wr(4'h0, 16'hFFFF);
    rd(4'h0, 16'h3333);
    wr(4'h0, 16'h1230);
    hs(16'h1111);
    hs(16'h2222);
    rd(4'h5, 16'h1230);
    tend("handshake");
    wr(4'h3, 16'hFFFF);
    rd(4'h3, 16'h1111);
    rd(4'h4, 16'h1111);
    i_src.step(4'hF);
    cnts(64'hFFFF_0000_0000_0001);
    i_src.step(4'hF);
    cnts(64'hFFFF_0001_FFFF_0001);
    tend("count");
    @(posedge core_clk);
    prog_halt <= 1'b1;
    repeat (10) @(posedge core_clk);
    rd(4'h8, 16'h0001);
    i_src.step(4'h1);
    i_src.step(4'h1);
    rd(4'h8, 16'h0001);
    @(posedge core_clk);
    prog_halt <= 1'b0;
    i_src.step(4'h1);
    i_src.step(4'h1);
    rd(4'h8, 16'h0002);
    tend("halt");
    wr(4'h3, 16'h1110);
    rd(4'h4, 16'h1110);
    i_src.step(4'h5);
    i_src.step(4'h5);
    // group 2 turned to down counting while running
    wr(4'h0, 16'h1330);
    hs(16'h0100);
    i_src.step(4'h4);
    i_src.step(4'h4);
    cnts(64'hFFFF_0001_FFFF_0002);
    tend("stop and direction");
    @(posedge core_clk);
    unit_offline <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(4'h4, 16'h0000);
    cnts(64'h0);
    @(posedge core_clk);
    unit_offline <= 1'b0;
    rd(4'h0, 16'h1330);
    @(posedge core_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(4'h0, 16'h0000);
    tend("offline and reset");
    wrap_up();
  end
endmodule : hs_updown_counter_groups_tb
`default_nettype wire
